// ==== src/sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;

   // Array geometry: 512K words of 36 bits, four lanes of 8 data bits and one parity bit.
   localparam int ADDR_W     = 19;
   localparam int DATA_W     = 36;
   localparam int LANES      = 4;
   localparam int LANE_W     = 9;
   localparam int UPPER_W    = 17;
   localparam int MEM_DEPTH  = 524288;

   // Data window sits this many registered edges after the address edge.
   localparam int DATA_LATENCY = 2;

   // Read data buffer between the array and the output register.
   localparam int RBUF_DEPTH = 2;

   // Reset values of the registered outputs and burst state.
   localparam logic [DATA_W-1:0] DATA_RESET  = 36'h0_0000_0000;
   localparam logic [1:0]        COUNT_RESET = 2'h0;

   // Operation carried down the pipeline.
   typedef enum logic [1:0] {
      CYC_NONE  = 2'b00,
      CYC_READ  = 2'b01,
      CYC_WRITE = 2'b10
   } cycle_t;

   // Type of the burst in progress, fixed at each address load.
   typedef enum logic [1:0] {
      BURST_DESEL = 2'b00,
      BURST_READ  = 2'b01,
      BURST_WRITE = 2'b10
   } burst_t;

   typedef struct packed {
      cycle_t              kind;
      logic [ADDR_W-1:0]   addr;
      logic [LANES-1:0]    lanes;
      logic                drive;
   } op_t;

   typedef struct packed {
      logic                valid;
      logic [ADDR_W-1:0]   addr;
      logic [LANES-1:0]    lanes;
      logic [DATA_W-1:0]   data;
   } hist_t;

endpackage

// ==== src/word_array.sv ====
`timescale 1ns/100ps
`default_nettype none
module word_array
   import sram_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Read port
   input  wire logic              rd_en,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data,
   // Write port with lane enables
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [LANES-1:0]  wr_lanes,
   input  wire logic [DATA_W-1:0] wr_data
);

   // The array itself has no reset; contents survive reset and sleep.
   logic [DATA_W-1:0] mem [MEM_DEPTH];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         for (int k = 0; k < LANES; k++) begin
            if (wr_lanes[k]) begin
               mem[wr_addr][k*LANE_W +: LANE_W] <= wr_data[k*LANE_W +: LANE_W];
            end
         end
      end
   end

   // A read in the same edge as a write returns the old word; the caller forwards.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data <= DATA_RESET;
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule
`default_nettype wire

// ==== src/word_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none
module word_buffer #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] slot;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
   } buf_state_t;

   buf_state_t st;
   buf_state_t next_st;
   logic       push;
   logic       pop;

   assign in_ready  = (st.count != CW'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data  = st.slot[st.rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.slot[st.wr_ptr] = in_data;
         next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + PW'(1);
      end
      if (pop) begin
         next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + PW'(1);
      end
      if (push && !pop) begin
         next_st.count = st.count + CW'(1);
      end else if (pop && !push) begin
         next_st.count = st.count - CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule
`default_nettype wire

// ==== src/sync_burst_sram_control.sv ====
// Overview of operation
// RULE1: On a load edge the read/write select alone picks read or write.
// RULE2: A burst keeps its read or write type until a new address loads.
// RULE3: Low read/write select enables lane writes; all lanes low writes whole word.
// RULE4: Burst order select high gives interleaved order, low gives linear order.
// RULE5: Interleaved bursts keep upper bits, low bits are start XOR access count.
// RULE6: Linear bursts keep upper bits, low bits count up modulo four.
// RULE7: After four accesses the burst wraps to its start and repeats.
// RULE8: Selected read load with output enable low reads and drives the bus.
// RULE9: Advancing a read burst with output enable low drives the next word.
// RULE10: A read loaded with output enable high runs but leaves the bus floating.
// RULE11: Advancing a read with output enable high steps address, bus stays floating.
// RULE12: Selected write load with a lane enabled writes bus data at given address.
// RULE13: Advancing a write burst writes next address in the enabled lanes only.
// RULE14: A write load with no lane enabled does nothing at all; the code still loads the address and the write burst type.
// RULE15: Advancing a write burst with no lane enabled steps but writes nothing.
// RULE16: Clock gate high makes the edge ignored; all state holds; the code still updates the output enable register.
// RULE17: Lane write group counts asserted when any of its four enables is low.
// RULE18: Strobe high advances the burst and ignores read/write select; low loads.
// RULE19: Chip selects matter only on load edges, not during burst advance.
// RULE20: Selected means select1 low, select2 high, select3 low; else deselect.
// RULE21: While the clock gate is high the previous cycle is stretched.
// RULE22: Advancing after a deselect stays deselected with the bus floating.
// RULE23: Sleep ignores all inputs, floats the bus and keeps the array.
// RULE24: Data sits a fixed two edges after its address, reads and writes alike.
// RULE25: Output enable high floats the data drivers whatever cycle runs.
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_control
   import sram_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Address and cycle control
   input  wire logic [ADDR_W-1:0] word_addr,
   input  wire logic              chip_sel1_n,
   input  wire logic              chip_sel2,
   input  wire logic              chip_sel3_n,
   input  wire logic              load_advance,
   input  wire logic              read_write_n,
   input  wire logic              lane0_write_en_n,
   input  wire logic              lane1_write_en_n,
   input  wire logic              lane2_write_en_n,
   input  wire logic              lane3_write_en_n,
   input  wire logic              clock_enable_n,
   // Output enable, sleep and static burst order
   input  wire logic              output_enable_n,
   input  wire logic              sleep_req,
   input  wire logic              burst_order_sel,
   // Data bus, lane k in bits 9k+8 down to 9k with parity on top
   input  wire logic [DATA_W-1:0] bus_data_in,
   output logic      [DATA_W-1:0] bus_data_out,
   output logic                   bus_data_oe
);

   typedef struct packed {
      burst_t             burst;
      logic [UPPER_W-1:0] upper;
      logic [1:0]         start;
      logic [1:0]         count;
      op_t                p1;
      op_t                p2;
      op_t                p3;
      hist_t              h1;
      hist_t              h2;
      logic [DATA_W-1:0]  data_out;
      logic               drive;
      logic               oe;
   } ctrl_state_t;

   ctrl_state_t       st;
   ctrl_state_t       next_st;
   op_t               op;
   hist_t             live;
   logic              advance;
   logic              selected;
   logic [LANES-1:0]  lanes_req;
   logic              lane_write_group_n;
   logic [1:0]        step;
   logic [1:0]        burst_low;
   logic [DATA_W-1:0] mem_rd_data;
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic [DATA_W-1:0] buf_out_data;

   // Sleep is folded into the edge gate so no pipeline state moves while asleep.
   assign advance   = !clock_enable_n && !sleep_req && buf_in_ready; // RULE16 RULE21 RULE23
   assign selected  = !chip_sel1_n && chip_sel2 && !chip_sel3_n; // RULE20
   assign lanes_req = ~{lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n};
   assign lane_write_group_n = (lanes_req == 4'h0); // RULE17
   assign step      = st.count + 2'h1; // RULE7
   assign burst_low = burst_order_sel ? (st.start ^ step) : (st.start + step); // RULE4 RULE5 RULE6

   // The write being committed this edge, with its data sampled straight off the bus.
   assign live = '{valid: (st.p3.kind == CYC_WRITE), addr: st.p3.addr,
                   lanes: st.p3.lanes, data: bus_data_in};

   function automatic logic [DATA_W-1:0] merge_write(input logic [DATA_W-1:0] base,
                                                     input hist_t             h,
                                                     input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] res;
      res = base;
      for (int k = 0; k < LANES; k++) begin
         if (h.valid && (h.addr == a) && h.lanes[k]) begin
            res[k*LANE_W +: LANE_W] = h.data[k*LANE_W +: LANE_W];
         end
      end
      return res;
   endfunction

   // Cycle decode for the current edge.
   always_comb begin
      op = '{kind: CYC_NONE, addr: {st.upper, burst_low}, lanes: lanes_req,
             drive: !output_enable_n};
      if (!load_advance) begin
         op.addr = word_addr;
         if (selected) begin // RULE19
            if (read_write_n) begin // RULE1
               op.kind = CYC_READ; // RULE8 RULE10
            end else if (!lane_write_group_n) begin
               op.kind = CYC_WRITE; // RULE3 RULE12
            end else begin
               op.kind = CYC_NONE; // RULE14
            end
         end
      end else begin
         unique case (st.burst) // RULE18 RULE2
            BURST_READ: begin
               op.kind = CYC_READ; // RULE9 RULE11
            end
            BURST_WRITE: begin
               op.kind = lane_write_group_n ? CYC_NONE : CYC_WRITE; // RULE13 RULE15
            end
            BURST_DESEL: begin
               op.kind = CYC_NONE; // RULE22
            end
            default: begin
               op.kind = CYC_NONE;
            end
         endcase
      end
   end

   // Next state; only the output enable moves on an ignored edge.
   always_comb begin
      next_st = st;
      if (advance) begin
         if (!load_advance) begin
            if (selected) begin
               next_st.burst = read_write_n ? BURST_READ : BURST_WRITE; // RULE1 RULE2
               next_st.upper = word_addr[ADDR_W-1:2];
               next_st.start = word_addr[1:0];
               next_st.count = COUNT_RESET;
            end else begin
               next_st.burst = BURST_DESEL; // RULE20
            end
         end else begin
            next_st.count = step; // RULE5 RULE6 RULE7
         end
         next_st.p1 = op;
         next_st.p2 = st.p1;
         next_st.p3 = st.p2;
         next_st.h1 = live;
         next_st.h2 = st.h1;
         // Reads taken from the array two edges ago miss up to three later commits.
         if (st.p2.kind == CYC_READ) begin
            next_st.data_out = merge_write(merge_write(merge_write(buf_out_data, st.h2,
                               st.p2.addr), st.h1, st.p2.addr), live, st.p2.addr); // RULE24
            next_st.drive = st.p2.drive; // RULE8 RULE10
         end else begin
            next_st.drive = 1'b0;
         end
      end
      // Output enable acts on every edge, even a stalled one.
      next_st.oe = next_st.drive && !output_enable_n && !sleep_req; // RULE25 RULE23
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st          <= '0;
         st.data_out <= DATA_RESET;
         st.count    <= COUNT_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign bus_data_out = st.data_out;
   assign bus_data_oe  = st.oe;

   word_array u_array (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .rd_en    (advance),
      .rd_addr  (op.addr),
      .rd_data  (mem_rd_data),
      .wr_en    (advance && (st.p3.kind == CYC_WRITE)), // RULE13
      .wr_addr  (st.p3.addr),
      .wr_lanes (st.p3.lanes),
      .wr_data  (bus_data_in)
   );

   // The buffer fills and drains in step with the pipeline; a full buffer stalls it.
   word_buffer #(
      .WIDTH (DATA_W),
      .DEPTH (RBUF_DEPTH)
   ) u_rbuf (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (advance && (st.p1.kind == CYC_READ)),
      .in_ready  (buf_in_ready),
      .in_data   (mem_rd_data),
      .out_valid (buf_out_valid),
      .out_ready (advance && (st.p2.kind == CYC_READ)),
      .out_data  (buf_out_data)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_read_start: assert property (advance && !load_advance && selected && read_write_n // RULE8
      |=> st.p1.kind == CYC_READ && st.p1.addr == $past(word_addr))
      else $error("read load not taken");

   a_write_start: assert property (advance && !load_advance && selected && !read_write_n // RULE12
      && !lane_write_group_n |=> st.p1.kind == CYC_WRITE && st.burst == BURST_WRITE)
      else $error("write load not taken");

   a_write_abort: assert property (advance && !load_advance && selected && !read_write_n // RULE14
      && lane_write_group_n |=> st.p1.kind == CYC_NONE && st.burst == BURST_WRITE)
      else $error("write abort used an address");

   a_full_word: assert property (advance && !load_advance && selected && !read_write_n // RULE3
      && lanes_req == 4'hF |=> st.p1.lanes == 4'hF)
      else $error("full width write lost lanes");

   a_deselect: assert property (advance && !load_advance && !selected // RULE20
      |=> st.burst == BURST_DESEL && st.p1.kind == CYC_NONE)
      else $error("deselect not honoured");

   a_desel_hold: assert property (advance && load_advance && st.burst == BURST_DESEL // RULE22
      |=> st.burst == BURST_DESEL && st.p1.kind == CYC_NONE)
      else $error("left deselect without load");

   a_type_kept: assert property (advance && load_advance && st.burst == BURST_READ // RULE2
      |=> st.burst == BURST_READ && st.p1.kind == CYC_READ)
      else $error("read burst changed type");

   a_interleave: assert property (advance && load_advance && st.burst == BURST_READ // RULE5
      && burst_order_sel |=> st.p1.addr[1:0] == ($past(st.start) ^ st.count)
      && st.p1.addr[ADDR_W-1:2] == st.upper)
      else $error("interleaved address wrong");

   a_linear: assert property (advance && load_advance && st.burst == BURST_READ // RULE6
      && !burst_order_sel |=> st.p1.addr[1:0] == $past(st.start) + st.count)
      else $error("linear address wrong");

   a_stall_hold: assert property (!advance |=> $stable(st.p1) && $stable(st.burst) // RULE16
      && $stable(st.count) && $stable(bus_data_out))
      else $error("state moved on ignored edge");

   a_oe_forced: assert property (output_enable_n || sleep_req |=> !bus_data_oe) // RULE25
      else $error("bus driven with drivers disabled");

   a_read_latency: assert property (advance && !load_advance && selected && read_write_n // RULE24
      && !output_enable_n ##1 (advance && !output_enable_n)[*2] |=> bus_data_oe)
      else $error("read data not on bus two edges later");

   a_no_empty_write: assert property (advance && st.p3.kind == CYC_WRITE // RULE15
      |-> st.p3.lanes != 4'h0)
      else $error("write committed with no lane");

   a_buffer_ready: assert property (advance && st.p2.kind == CYC_READ |-> buf_out_valid)
      else $error("read buffer empty at output");

   // Advance keeps the loaded address and type, so selects and read/write must not leak in.

   a_adv_step: assert property (advance && load_advance // RULE18
      |=> st.count == $past(st.count) + 2'h1)
      else $error("burst counter did not step");

   a_sel_ignored: assert property (advance && load_advance // RULE19
      |=> $stable(st.upper) && $stable(st.start))
      else $error("advance reloaded the address");

   a_burst_latch: assert property (advance && !load_advance && selected // RULE18
      |=> st.upper == $past(word_addr[ADDR_W-1:2]) && st.start == $past(word_addr[1:0])
      && st.count == COUNT_RESET)
      else $error("load did not latch the address");

   a_wrap_start: assert property (advance && load_advance && st.burst == BURST_READ // RULE7
      && st.count == 2'h3 |=> st.p1.addr[1:0] == st.start)
      else $error("burst did not wrap to start");

   a_write_kept: assert property (advance && load_advance && st.burst == BURST_WRITE // RULE2
      |=> st.burst == BURST_WRITE)
      else $error("write burst changed type");

   a_write_lanes: assert property (advance && load_advance && !lane_write_group_n // RULE13
      && st.burst == BURST_WRITE
      |=> st.p1.kind == CYC_WRITE && st.p1.lanes == $past(lanes_req))
      else $error("burst write lanes wrong");

   a_abort_step: assert property (advance && load_advance && lane_write_group_n // RULE15
      && st.burst == BURST_WRITE |=> st.p1.kind == CYC_NONE)
      else $error("aborted burst write used a lane");

   // A dummy read still walks the burst; only its drive bit differs from a real read.

   a_dummy_read: assert property (advance && !load_advance && selected && read_write_n // RULE10
      && output_enable_n |=> st.p1.kind == CYC_READ && !st.p1.drive)
      else $error("dummy read mis-decoded");

   a_dummy_adv: assert property (advance && load_advance && st.burst == BURST_READ // RULE11
      && output_enable_n |=> st.p1.kind == CYC_READ && !st.p1.drive)
      else $error("dummy advance mis-decoded");

   a_read_drive: assert property (advance && st.p2.kind == CYC_READ && st.p2.drive // RULE9
      && !output_enable_n |=> bus_data_oe)
      else $error("read data not driven");

   a_write_float: assert property (advance && st.p2.kind != CYC_READ // RULE24
      |=> !bus_data_oe)
      else $error("bus driven outside a read slot");

   a_sleep_hold: assert property (sleep_req // RULE23
      |=> $stable(st.burst) && $stable(st.count) && !bus_data_oe)
      else $error("sleep let state move");

   a_stall_oe: assert property (!advance && !output_enable_n && !sleep_req // RULE21
      |=> bus_data_oe == $past(st.drive))
      else $error("stall changed the drive state");

   c_full_burst: cover property (advance && !load_advance && selected && read_write_n
      ##1 (advance && load_advance)[*3]);

   c_write_read: cover property (st.p3.kind == CYC_WRITE && st.p2.kind == CYC_READ && advance);

   c_stall: cover property (clock_enable_n && st.p1.kind != CYC_NONE);

   c_sleep: cover property (sleep_req ##1 !sleep_req && advance);

   c_oe_cut: cover property (st.drive && output_enable_n && advance);

endmodule
`default_nettype wire

// ==== verification/ctrl_bus_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ctrl_bus_model
   import sram_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // Cycle control as driven to the device
   input  wire logic              adv_edge,
   input  wire logic              load_advance,
   input  wire logic              read_write_n,
   input  wire logic              selected,
   input  wire logic              lanes_on,
   input  wire logic [DATA_W-1:0] wr_word,
   // Shared data bus
   input  wire logic [DATA_W-1:0] dev_data,
   input  wire logic              dev_oe,
   output logic      [DATA_W-1:0] bus_wire,
   output logic                   clash
);
   logic              wr_burst;
   logic              wr_now;
   logic [2:0]        pend;
   logic [DATA_W-1:0] wd0;
   logic [DATA_W-1:0] wd1;
   logic [DATA_W-1:0] wd2;
   logic [DATA_W-1:0] float_pat;

   always_comb begin
      wr_now = load_advance ? wr_burst : (selected && !read_write_n);
      wr_now = wr_now && lanes_on;
   end

   always_ff @(posedge clk_sys) begin
      float_pat <= rst ? 36'h5_A5A5_A5A5 : ~bus_wire;
      if (rst) begin
         wr_burst <= 1'b0;
         pend <= 3'h0;
      end else if (adv_edge) begin
         if (!load_advance) begin
            wr_burst <= selected && !read_write_n;
         end
         pend <= {pend[1:0], wr_now};
         wd0 <= wr_word;
         wd1 <= wd0;
         wd2 <= wd1;
      end
   end

   // A released bus toggles every cycle, so stale data never passes for a read.
   assign bus_wire = dev_oe ? dev_data : (pend[2] ? wd2 : float_pat);
   assign clash = dev_oe && pend[2];
endmodule
`default_nettype wire

// ==== verification/sync_burst_sram_control_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_control_tb_top
   import sram_ctrl_pkg::*;
;
   typedef struct packed {
      logic [3:0] ctl;
      logic [3:0] selc;
      logic [3:0] lanes;
      logic [3:0] alo;
      logic [3:0] ea;
   } row_t;
   typedef struct packed {
      logic              oe;
      logic [DATA_W-1:0] d;
   } exp_t;

   localparam logic [14:0] BASE = 15'h48D1;
   localparam logic [DATA_W-1:0] HAND = 36'h0_DEAD_BEEF;
   localparam row_t IDLE = 20'h21F00;
   localparam int NROWS = 26;
   // Fields: ctl = {order, load_advance, read_write_n, output_enable_n}, select case
   // (0 selected, 1..3 one select off), lane enables, address low nibble, expected low bits.
   localparam row_t ROWS [NROWS] = '{
      20'h80011, 20'hC0000, 20'hC0003, 20'hC0002, 20'hA0F22, 20'hC1F03, 20'hC0F00,
      20'hC0F01, 20'hC0F02, 20'h21F00, 20'h40000, 20'h00E33, 20'h40F00, 20'h40701,
      20'h20F33, 20'h40F00, 20'h40F01, 20'h40F02, 20'h40F03, 20'h22F00, 20'h23F00,
      20'h00F00, 20'h30F00, 20'h50F01, 20'h20F00, 20'h40F01};

   logic clk_sys, rst, load_advance, read_write_n, clock_enable_n;
   logic chip_sel1_n, chip_sel2, chip_sel3_n, output_enable_n, sleep_req, burst_order_sel;
   logic lane0_write_en_n, lane1_write_en_n, lane2_write_en_n, lane3_write_en_n;
   logic              bus_data_oe;
   logic              clash;
   logic [ADDR_W-1:0] word_addr;
   logic [DATA_W-1:0] bus_data_out;
   logic [DATA_W-1:0] bus_wire;
   logic [DATA_W-1:0] wr_word;
   logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
   logic [UPPER_W-1:0] upper;
   burst_t            cur;
   exp_t              ex [3];
   int                err_count = 0;
   int                n_tests = 0;

   sync_burst_sram_control u_sync_burst_sram_control (
      .clk_sys          (clk_sys),
      .rst              (rst),
      .word_addr        (word_addr),
      .chip_sel1_n      (chip_sel1_n),
      .chip_sel2        (chip_sel2),
      .chip_sel3_n      (chip_sel3_n),
      .load_advance     (load_advance),
      .read_write_n     (read_write_n),
      .lane0_write_en_n (lane0_write_en_n),
      .lane1_write_en_n (lane1_write_en_n),
      .lane2_write_en_n (lane2_write_en_n),
      .lane3_write_en_n (lane3_write_en_n),
      .clock_enable_n   (clock_enable_n),
      .output_enable_n  (output_enable_n),
      .sleep_req        (sleep_req),
      .burst_order_sel  (burst_order_sel),
      .bus_data_in      (bus_wire),
      .bus_data_out     (bus_data_out),
      .bus_data_oe      (bus_data_oe)
   );

   ctrl_bus_model u_ctrl_bus_model (
      .clk_sys      (clk_sys),
      .rst          (rst),
      .adv_edge     (!clock_enable_n && !sleep_req),
      .load_advance (load_advance),
      .read_write_n (read_write_n),
      .selected     (!chip_sel1_n && chip_sel2 && !chip_sel3_n),
      .lanes_on     (!(lane0_write_en_n && lane1_write_en_n && lane2_write_en_n
                       && lane3_write_en_n)),
      .wr_word      (wr_word),
      .dev_data     (bus_data_out),
      .dev_oe       (bus_data_oe),
      .bus_wire     (bus_wire),
      .clash        (clash)
   );

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic cmp_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic drive(input row_t r, input logic ce_n, input logic zz,
                        input logic [DATA_W-1:0] wd);
      burst_order_sel = r.ctl[3];
      load_advance = r.ctl[2];
      read_write_n = r.ctl[1];
      output_enable_n = r.ctl[0];
      chip_sel1_n = (r.selc == 4'h1);
      chip_sel2 = (r.selc != 4'h2);
      chip_sel3_n = (r.selc == 4'h3);
      {lane3_write_en_n, lane2_write_en_n, lane1_write_en_n, lane0_write_en_n} = r.lanes;
      word_addr = {BASE, r.alo};
      clock_enable_n = ce_n;
      sleep_req = zz;
      wr_word = wd;
   endtask

   // Expectations move only on taken edges, so a stall checks that outputs hold and a sleep checks that the bus floats.
   task automatic step(input row_t r, input logic ce_n, input logic zz,
                       input logic [DATA_W-1:0] wd);
      logic [ADDR_W-1:0] a;
      logic              exp_oe;
      drive(r, ce_n, zz, wd);
      @(posedge clk_sys);
      #1;
      if (!ce_n && !zz) begin
         if (!r.ctl[2]) begin
            cur = (r.selc != 4'h0) ? BURST_DESEL : (r.ctl[1] ? BURST_READ : BURST_WRITE);
            upper = {BASE, r.alo[3:2]};
         end
         a = {upper, r.ea[1:0]};
         ex[2] = ex[1];
         ex[1] = ex[0];
         ex[0].oe = (cur == BURST_READ) && !r.ctl[0];
         ex[0].d = ref_mem.exists(a) ? ref_mem[a] : DATA_RESET;
         for (int k = 0; k < LANES; k++) begin
            if (cur == BURST_WRITE && !r.lanes[k]) begin
               ref_mem[a][k*LANE_W +: LANE_W] = wd[k*LANE_W +: LANE_W];
            end
         end
      end
      // Output enable and sleep gate the drivers at every edge, stalled ones too.
      exp_oe = ex[2].oe && !r.ctl[0] && !zz;
      cmp_bit(bus_data_oe, exp_oe);
      if (exp_oe) begin
         cmp_word(bus_wire, ex[2].d);
      end
      cmp_bit(clash, 1'b0);
   endtask

   task automatic complete_run();
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      ex = '{default: '0};
      cur = BURST_DESEL;
      upper = '0;
      rst = 1'b1;
      drive(IDLE, 1'b0, 1'b0, DATA_RESET);
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      cmp_bit(bus_data_oe, 1'b0);
      cmp_word(bus_data_out, DATA_RESET);
      for (int i = 0; i < NROWS; i++) begin
         step(ROWS[i], 1'b0, 1'b0, 36'h1_2345_6789 * (i + 1));
      end
      repeat (3) step(IDLE, 1'b0, 1'b0, HAND);
      // Stalled edges carry a selected write load that must leave no trace.
      step(20'hA0F00, 1'b0, 1'b0, HAND);
      step(20'hC0F01, 1'b0, 1'b0, HAND);
      repeat (3) step(20'h80000, 1'b1, 1'b0, HAND);
      step(20'hC0F02, 1'b0, 1'b0, HAND);
      step(20'h80000, 1'b1, 1'b0, HAND);
      step(20'hC0F03, 1'b0, 1'b0, HAND);
      repeat (3) step(IDLE, 1'b0, 1'b0, HAND);
      repeat (4) step(20'h00000, 1'b0, 1'b1, HAND);
      step(20'h20F00, 1'b0, 1'b0, HAND);
      step(20'h40F01, 1'b0, 1'b0, HAND);
      step(20'h40F02, 1'b0, 1'b0, HAND);
      step(20'h40F03, 1'b0, 1'b0, HAND);
      step(20'h50F00, 1'b0, 1'b0, HAND);
      repeat (3) step(IDLE, 1'b0, 1'b0, HAND);
      complete_run();
   end

   initial begin
      repeat (600) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
